// >>> src/tcr_defines.svh
//----------------------------------------------------------
// constants for the control and status register set
//----------------------------------------------------------
// Purpose: offsets, field positions and reset values
// Assumes: direct word addressing, 16-bit data
// Notes:   definitions only
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH

`define TCR_ADDR_W     12
`define TCR_DATA_W     16
`define TCR_LINKS      16
`define TCR_PAIRS      8
`define TCR_STAT_W     4

// register offsets (word addresses)
`define TCR_OFS_RESET  12'h299
`define TCR_OFS_TXLC   12'h318
`define TCR_TXLC_HI    9'h063
`define TCR_OFS_INMODE 12'h402
`define TCR_OFS_STATUS 12'h40e

// reset values
`define TCR_RST_RESET  9'h000
`define TCR_RST_TXLC   16'h0808
`define TCR_RST_INMODE 16'h0000
`define TCR_RST_STATUS 4'h0

// global reset register fields
`define TCR_RESET_KEEP 9
`define TCR_BIT_RX_RST 7
`define TCR_BIT_TX_RST 6
`define TCR_BIT_CN_RST 5

// per-link byte of a link pair register
`define TCR_BIT_USER   7
`define TCR_BIT_COSET  5
`define TCR_BIT_SCRAM  4
`define TCR_HI_BYTE    8

// status register fields
`define TCR_BIT_OCLK   3
`define TCR_BIT_ICLK   2
`define TCR_BIT_FIFO   1
`define TCR_BIT_RAM    0

`endif

// >>> src/tcr_pkg.sv
//----------------------------------------------------------
// types shared by the register set
//----------------------------------------------------------
// Purpose: carrier structs for requests and controls
// Assumes: tcr_defines.svh supplies widths
// Notes:   nothing here is imported
`include "tcr_defines.svh"

package tcr_pkg;

  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`TCR_ADDR_W-1:0] addr;
    logic [`TCR_DATA_W-1:0] wdata;
  } tcr_req_t;

  typedef struct packed {
    logic rx;
    logic tx;
    logic cnt;
    logic full;
  } tcr_resets_t;

  typedef struct packed {
    logic [`TCR_LINKS-1:0] user_only;
    logic [`TCR_LINKS-1:0] coset_add;
    logic [`TCR_LINKS-1:0] scramble;
  } tcr_txcfg_t;

endpackage

// >>> src/tcr_sync3.sv
//----------------------------------------------------------
// three-stage input synchroniser with agreement filter
//----------------------------------------------------------
// Purpose: bring asynchronous alarm levels into core clock
// Assumes: inputs are levels, not pulses
// Notes:   output follows only when stages two and three agree
module tcr_sync3 #(
  parameter int W = 2
) (
  input  wire logic         core_clk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          s1[g]        <= 1'b0;
          s2[g]        <= 1'b0;
          s3[g]        <= 1'b0;
          level_out[g] <= 1'b0;
        end
        else
        begin
          s1[g] <= async_in[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g])
            level_out[g] <= s3[g];
        end
      end
    end
  endgenerate

endmodule

// >>> src/tcr_sticky.sv
//----------------------------------------------------------
// latched status bits, set wins over clear
//----------------------------------------------------------
// Purpose: hold alarm events until software clears them
// Assumes: set and clear are single-cycle qualified
// Notes:   a set in the clearing cycle keeps the bit
module tcr_sticky #(
  parameter int W = 4
) (
  input  wire logic         core_clk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output logic      [W-1:0] flag_out
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          flag_out[g] <= 1'b0;
        else if (set_in[g])
          flag_out[g] <= 1'b1;
        else if (clr_in[g])
          flag_out[g] <= 1'b0;
      end
    end
  endgenerate

endmodule

// >>> src/tcr_regs.sv
//----------------------------------------------------------
// reset, transmit link and alarm register set
//----------------------------------------------------------
// Purpose: software control and status of the TC device
// Assumes: direct word access, one cycle strobes
// Notes:   read data appears the cycle after the strobe
`include "tcr_defines.svh"
module tcr_regs (
  input  wire logic                   core_clk_in,
  input  wire logic                   resetn_in,
  input  tcr_pkg::tcr_req_t           host_req_in,
  output logic [`TCR_DATA_W-1:0]      rd_data_out,
  output logic                        rd_valid_out,
  output tcr_pkg::tcr_resets_t        resets_out,
  output tcr_pkg::tcr_txcfg_t         txcfg_out,
  output logic [`TCR_LINKS-1:0]       in_user_only_out,
  input  wire logic                   oclk_loss_in,
  input  wire logic                   iclk_loss_in,
  input  wire logic                   fifo_ovf_in,
  input  wire logic                   ram_empty_in,
  output logic [`TCR_STAT_W-1:0]      status_out
);

  //--------------------------------------------------------
  // address decode
  //--------------------------------------------------------
  logic [`TCR_DATA_W-1:0] wd;
  logic [2:0]             pair_idx;
  logic                   sel_rst;
  logic                   sel_txlc;
  logic                   sel_inm;
  logic                   sel_stat;
  logic                   wr_rst;
  logic                   wr_txlc;
  logic                   wr_inm;
  logic                   wr_stat;

  assign wd       = host_req_in.wdata;
  assign pair_idx = host_req_in.addr[2:0];
  assign sel_rst  = host_req_in.addr == `TCR_OFS_RESET;
  assign sel_txlc = host_req_in.addr[`TCR_ADDR_W-1:3] == `TCR_TXLC_HI;
  assign sel_inm  = host_req_in.addr == `TCR_OFS_INMODE;
  assign sel_stat = host_req_in.addr == `TCR_OFS_STATUS;
  assign wr_rst   = host_req_in.wr && sel_rst;
  assign wr_txlc  = host_req_in.wr && sel_txlc;
  assign wr_inm   = host_req_in.wr && sel_inm;
  assign wr_stat  = host_req_in.wr && sel_stat;

  //--------------------------------------------------------
  // global reset register and command pulses
  //--------------------------------------------------------
  logic [`TCR_RESET_KEEP-1:0] rst_keep;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_keep <= `TCR_RST_RESET;
    else if (wr_rst)
      rst_keep <= wd[`TCR_RESET_KEEP-1:0];
  end

  // one pulse per write, released without a second write
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      resets_out <= '0;
    else
    begin
      resets_out.rx   <= wr_rst && wd[`TCR_BIT_RX_RST];
      resets_out.tx   <= wr_rst && wd[`TCR_BIT_TX_RST];
      resets_out.cnt  <= wr_rst && wd[`TCR_BIT_CN_RST];
      resets_out.full <= wr_rst && wd[`TCR_BIT_RX_RST]
                         && wd[`TCR_BIT_TX_RST]
                         && wd[`TCR_BIT_CN_RST];
    end
  end

  //--------------------------------------------------------
  // transmit link pair registers
  //--------------------------------------------------------
  logic [`TCR_DATA_W-1:0] txlc [`TCR_PAIRS];

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < `TCR_PAIRS; i++)
        txlc[i] <= `TCR_RST_TXLC;
    end
    else if (wr_txlc)
      txlc[pair_idx] <= wd;
  end

  genvar g;
  generate
    for (g = 0; g < `TCR_PAIRS; g++)
    begin : g_pair
      // lower byte drives link g, upper byte link g+8
      assign txcfg_out.user_only[g] = txlc[g][`TCR_BIT_USER];
      assign txcfg_out.coset_add[g] = !txlc[g][`TCR_BIT_COSET];
      assign txcfg_out.scramble[g]  = txlc[g][`TCR_BIT_SCRAM];
      assign txcfg_out.user_only[g+`TCR_PAIRS] =
        txlc[g][`TCR_HI_BYTE+`TCR_BIT_USER];
      assign txcfg_out.coset_add[g+`TCR_PAIRS] =
        !txlc[g][`TCR_HI_BYTE+`TCR_BIT_COSET];
      assign txcfg_out.scramble[g+`TCR_PAIRS] =
        txlc[g][`TCR_HI_BYTE+`TCR_BIT_SCRAM];
    end
  endgenerate

  //--------------------------------------------------------
  // input cell counter mode
  //--------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      in_user_only_out <= `TCR_RST_INMODE;
    else if (wr_inm)
      in_user_only_out <= wd;
  end

  //--------------------------------------------------------
  // alarm status
  //--------------------------------------------------------
  logic [1:0]             clk_loss;
  logic [`TCR_STAT_W-1:0] stat_set;
  logic [`TCR_STAT_W-1:0] stat_clr;

  // clock loss detectors sit in other domains
  tcr_sync3 #(
    .W (2)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .async_in    ({oclk_loss_in, iclk_loss_in}),
    .level_out   (clk_loss)
  );

  always_comb
  begin
    stat_set                = '0;
    stat_set[`TCR_BIT_OCLK] = clk_loss[1];
    stat_set[`TCR_BIT_ICLK] = clk_loss[0];
    stat_set[`TCR_BIT_FIFO] = fifo_ovf_in;
    stat_set[`TCR_BIT_RAM]  = ram_empty_in;
  end

  // writing zero clears, writing one leaves the bit
  assign stat_clr = {`TCR_STAT_W{wr_stat}} & ~wd[`TCR_STAT_W-1:0];

  tcr_sticky #(
    .W (`TCR_STAT_W)
  ) u_sticky (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .set_in      (stat_set),
    .clr_in      (stat_clr),
    .flag_out    (status_out)
  );

  //--------------------------------------------------------
  // read back
  //--------------------------------------------------------
  logic [`TCR_DATA_W-1:0] next_rd_data;

  always_comb
  begin
    next_rd_data = '0;
    if (sel_rst)
      next_rd_data = `TCR_DATA_W'(rst_keep);
    else if (sel_txlc)
      next_rd_data = txlc[pair_idx];
    else if (sel_inm)
      next_rd_data = in_user_only_out;
    else if (sel_stat)
      next_rd_data = `TCR_DATA_W'(status_out);
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= host_req_in.rd;
      if (host_req_in.rd)
        rd_data_out <= next_rd_data;
    end
  end

  //--------------------------------------------------------
  // assertions
  //--------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  AST_RX_RESET_PULSE : assert property (
    wr_rst && wd[`TCR_BIT_RX_RST] |=> resets_out.rx)
    else $error("receiver reset pulse missing");

  AST_TX_RESET_PULSE : assert property (
    wr_rst |=> resets_out.tx == $past(wd[`TCR_BIT_TX_RST]))
    else $error("transmitter reset pulse wrong");

  AST_CNT_RESET_PULSE : assert property (
    $rose(resets_out.cnt) |-> $past(wr_rst) && $past(wd[`TCR_BIT_CN_RST]))
    else $error("counter reset without a write");

  AST_RESET_UPPER_ZERO : assert property (
    host_req_in.rd && sel_rst |=> rd_valid_out && rd_data_out[15:9] == 7'h00)
    else $error("reset register upper bits not zero");

  AST_PAIR_LOW : assert property (
    wr_txlc |=> txcfg_out.user_only[$past(pair_idx)] == $past(wd[7]))
    else $error("low link of pair not updated");

  AST_PAIR_HIGH : assert property (
    wr_txlc |=> txcfg_out.user_only[$past(pair_idx) + 4'h8] == $past(wd[15]))
    else $error("high link of pair not updated");

  AST_COSET_INVERT : assert property (
    wr_txlc |=> txcfg_out.coset_add[$past(pair_idx) + 4'h8] == !$past(wd[13]))
    else $error("coset control polarity wrong");

  AST_SCRAMBLE : assert property (
    wr_txlc |=> txcfg_out.scramble[$past(pair_idx)] == $past(wd[4]))
    else $error("scramble control not updated");

  AST_IN_MODE : assert property (
    wr_inm |=> in_user_only_out == $past(wd))
    else $error("input count mode not stored");

  AST_OCLK_HOLD : assert property (
    status_out[3] && !(wr_stat && !wd[3]) |=> status_out[3])
    else $error("output clock loss flag dropped");

  AST_ICLK_SET : assert property (
    clk_loss[0] |=> status_out[2])
    else $error("input clock loss flag not set");

  AST_FIFO_LATCH : assert property (
    fifo_ovf_in ##1 !fifo_ovf_in && !(wr_stat && !wd[1]) |=> status_out[1])
    else $error("fifo overflow flag not latched");

  AST_RAM_CLEAR : assert property (
    wr_stat && !wd[0] && !ram_empty_in |=> !status_out[0])
    else $error("cell memory flag not cleared");

  AST_FULL_RESET : assert property (
    resets_out.full |-> resets_out.rx && resets_out.tx && resets_out.cnt)
    else $error("full reset without all three");

  AST_SINGLE_PULSE : assert property (
    resets_out.rx && !(wr_rst && wd[7]) |=> !resets_out.rx)
    else $error("receiver reset stuck");

  AST_COSET_LOW : assert property (
    wr_txlc |=> txcfg_out.coset_add[$past(pair_idx)] == !$past(wd[5]))
    else $error("low link coset control wrong");

  AST_IN_MODE_READ : assert property (
    host_req_in.rd && sel_inm |=> rd_valid_out && rd_data_out == $past(in_user_only_out))
    else $error("input count mode read back wrong");

  AST_OCLK_SET : assert property (
    clk_loss[1] |=> status_out[3])
    else $error("output clock loss flag not set");

  AST_ICLK_CLEAR : assert property (
    wr_stat && !wd[2] && !clk_loss[0] |=> !status_out[2])
    else $error("input clock loss flag not cleared");

  AST_FIFO_SET : assert property (
    fifo_ovf_in |=> status_out[1])
    else $error("fifo overflow flag not set");

  AST_RAM_SET : assert property (
    ram_empty_in |=> status_out[0])
    else $error("cell memory flag not set");

  COV_FULL_RESET : cover property (wr_rst && wd[7:5] == 3'h7 ##1 resets_out.full);
  COV_PAIR_WRITE : cover property (wr_txlc && pair_idx == 3'h7);
  COV_SET_BEATS_CLEAR : cover property (wr_stat && !wd[1] && fifo_ovf_in ##1 status_out[1]);
  COV_CLOCK_LOSS : cover property (clk_loss[1] ##1 status_out[3]);

endmodule

// >>> dv/tcr_regs_bench.sv
//----------------------------------------------------------
// self-checking bench for the register set
//----------------------------------------------------------
// Purpose: drive word accesses and alarm inputs, compare outputs
// Assumes: one-cycle strobes, read answer one cycle later
// Notes:   all stimulus by non-blocking assignment at rising edge
`include "tcr_defines.svh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tcr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                      core_clk_in = 1'b0;
  logic                      resetn_in   = 1'b0;
  tcr_pkg::tcr_req_t         host_req_in = '0;
  logic [`TCR_DATA_W-1:0]    rd_data_out;
  logic                      rd_valid_out;
  tcr_pkg::tcr_resets_t      resets_out;
  tcr_pkg::tcr_txcfg_t       txcfg_out;
  logic [`TCR_LINKS-1:0]     in_user_only_out;
  logic                      oclk_loss_in = 1'b0;
  logic                      iclk_loss_in = 1'b0;
  logic                      fifo_ovf_in  = 1'b0;
  logic                      ram_empty_in = 1'b0;
  logic [`TCR_STAT_W-1:0]    status_out;
  int                        bad_count = 0;
  int                        checks    = 0;
  int                        cycles    = 0;
  logic [15:0]               uo;
  logic [15:0]               ca;
  logic [15:0]               sc;
  logic [15:0]               w;

  tcr_regs DUT (
    .core_clk_in      (core_clk_in),
    .resetn_in        (resetn_in),
    .host_req_in      (host_req_in),
    .rd_data_out      (rd_data_out),
    .rd_valid_out     (rd_valid_out),
    .resets_out       (resets_out),
    .txcfg_out        (txcfg_out),
    .in_user_only_out (in_user_only_out),
    .oclk_loss_in     (oclk_loss_in),
    .iclk_loss_in     (iclk_loss_in),
    .fifo_ovf_in      (fifo_ovf_in),
    .ram_empty_in     (ram_empty_in),
    .status_out       (status_out)
  );

  always #20 core_clk_in = ~core_clk_in;

  //----------------------------------------------------------
  // access tasks
  //----------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    host_req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_in);
    host_req_in.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    @(posedge core_clk_in);
    host_req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk_in);
    host_req_in.rd <= 1'b0;
    #1;
    `CHK("rd_valid", 1'b1, rd_valid_out)
    `CHK("rd_data", e, rd_data_out)
  endtask

  // write reset register, expect {rx,tx,cnt,full} for one cycle
  task automatic rst_cmd(input logic [15:0] d, input logic [3:0] e);
    wr_reg(`TCR_OFS_RESET, d);
    #1;
    `CHK("resets", e, resets_out)
    @(posedge core_clk_in);
    #1;
    `CHK("resets_idle", 4'h0, resets_out)
  endtask

  // hold clock-loss levels long enough for the synchroniser
  task automatic loss(input logic [1:0] v);
    @(posedge core_clk_in);
    {oclk_loss_in, iclk_loss_in} <= v;
    repeat (8) @(posedge core_clk_in);
    {oclk_loss_in, iclk_loss_in} <= 2'b00;
    repeat (6) @(posedge core_clk_in);
    #1;
  endtask

  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  //----------------------------------------------------------
  // main sequence
  //----------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    #1;
    `CHK("coset_rst", 16'hffff, txcfg_out.coset_add)
    rd_chk(`TCR_OFS_RESET, 16'h0000);
    rd_chk(`TCR_OFS_INMODE, 16'h0000);
    rd_chk(`TCR_OFS_STATUS, 16'h0000);
    rst_cmd(16'hfee0, 4'hf);
    rd_chk(`TCR_OFS_RESET, 16'h00e0);
    rst_cmd(16'h0080, 4'h8);
    rst_cmd(16'h0040, 4'h4);
    rst_cmd(16'h0020, 4'h2);
    rst_cmd(16'h00c0, 4'hc);
    rst_cmd(16'h0000, 4'h0);
    for (int n = 0; n < 8; n++)
    begin
      w = (n % 2) ? 16'h18a8 : 16'ha818;
      wr_reg(`TCR_OFS_TXLC + 12'(n), w);
      uo[n] = w[7];
      uo[n+8] = w[15];
      ca[n] = ~w[5];
      ca[n+8] = ~w[13];
      sc[n] = w[4];
      sc[n+8] = w[12];
    end
    wr_reg(12'h317, 16'hffff);
    wr_reg(12'h320, 16'hffff);
    #1;
    `CHK("user_only", uo, txcfg_out.user_only)
    `CHK("coset_add", ca, txcfg_out.coset_add)
    `CHK("scramble", sc, txcfg_out.scramble)
    for (int n = 0; n < 8; n++)
    begin
      rd_chk(`TCR_OFS_TXLC + 12'(n), (n % 2) ? 16'h18a8 : 16'ha818);
    end
    rd_chk(12'h320, 16'h0000);
    rd_chk(12'h317, 16'h0000);
    wr_reg(`TCR_OFS_INMODE, 16'ha5c3);
    #1;
    `CHK("in_user_only", 16'ha5c3, in_user_only_out)
    rd_chk(`TCR_OFS_INMODE, 16'ha5c3);
    @(posedge core_clk_in);
    fifo_ovf_in <= 1'b1;
    @(posedge core_clk_in);
    fifo_ovf_in <= 1'b0;
    ram_empty_in <= 1'b1;
    @(posedge core_clk_in);
    ram_empty_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
    `CHK("status_set", 4'h3, status_out)
    wr_reg(`TCR_OFS_STATUS, 16'hffff);
    #1;
    `CHK("status_w1", 4'h3, status_out)
    wr_reg(`TCR_OFS_STATUS, 16'hfffe);
    #1;
    `CHK("status_ram_clr", 4'h2, status_out)
    @(posedge core_clk_in);
    fifo_ovf_in <= 1'b1;
    wr_reg(`TCR_OFS_STATUS, 16'h0000);
    #1;
    `CHK("status_set_wins", 4'h2, status_out)
    @(posedge core_clk_in);
    fifo_ovf_in <= 1'b0;
    wr_reg(`TCR_OFS_STATUS, 16'hfffd);
    #1;
    `CHK("status_fifo_clr", 4'h0, status_out)
    loss(2'b10);
    `CHK("status_oclk", 4'h8, status_out)
    loss(2'b01);
    rd_chk(`TCR_OFS_STATUS, 16'h000c);
    wr_reg(`TCR_OFS_STATUS, 16'hfff7);
    #1;
    `CHK("status_oclk_clr", 4'h4, status_out)
    wr_reg(`TCR_OFS_STATUS, 16'hfffb);
    #1;
    `CHK("status_iclk_clr", 4'h0, status_out)
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    #1;
    `CHK("coset_rst2", 16'hffff, txcfg_out.coset_add)
    `CHK("user_only_rst2", 16'h0000, txcfg_out.user_only)
    `CHK("in_user_only_rst2", 16'h0000, in_user_only_out)
    rd_chk(`TCR_OFS_TXLC, 16'h0808);
    rd_chk(`TCR_OFS_INMODE, 16'h0000);
    tally_and_finish();
  end
endmodule
